// ---- tsf_defs.vh ----
// tsf_defs.vh: register map, field positions, reset values and timing counts
// assumes ref_clk at 40 MHz; included by the failover module and its test bench
`ifndef TSF_DEFS_VH
`define TSF_DEFS_VH

// clock rate and times
`define TSF_REF_CLK_KHZ      40000
`define TSF_STABLE_TIME_MS   10000
`define TSF_STABLE_CYCLES    (`TSF_STABLE_TIME_MS * `TSF_REF_CLK_KHZ)
`define TSF_DEAD_TIME_US     250
`define TSF_DEAD_CYCLES      ((`TSF_DEAD_TIME_US * `TSF_REF_CLK_KHZ) / 1000)
`define TSF_INT_HALF_CYCLES  13

// register word indexes (byte address = 4 * index)
`define TSF_REG_CTRL         3'h0
`define TSF_REG_PORTSEL      3'h1
`define TSF_REG_PORTCFG      3'h2
`define TSF_REG_STATUS       3'h3
`define TSF_REG_IRQ_STAT     3'h4
`define TSF_REG_IRQ_MASK     3'h5

// source choices
`define TSF_SRC_NETWORK_LINK_ONE         3'h0
`define TSF_SRC_NETWORK_LINK_TWO         3'h1
`define TSF_SRC_DROP         3'h2
`define TSF_SRC_INT          3'h3
`define TSF_SRC_EXT          3'h4
`define TSF_SRC_SYNC         3'h5

// external clock rate codes
`define TSF_RATE_8K          2'h0
`define TSF_RATE_1544K       2'h1
`define TSF_RATE_2048K       2'h2

// control register fields
`define TSF_CTRL_PRI_LSB     0
`define TSF_CTRL_SEC_LSB     4
`define TSF_CTRL_RATE_LSB    8
`define TSF_CTRL_PRI_ALM     12
`define TSF_CTRL_SEC_ALM     13
`define TSF_CTRL_RESET       32'h0000_3130

// interrupt status bits
`define TSF_IRQ_PRI_FAIL     0
`define TSF_IRQ_SEC_FAIL     1
`define TSF_IRQ_REVERT       2
`define TSF_IRQ_CFG_REJ      3

// candidate level vector layout
`define TSF_NUM_CAND         11
`define TSF_CAND_DROP0       4'h2
`define TSF_CAND_XTC0        4'h6
`define TSF_CAND_INT         4'ha

`endif

// ---- tsf_activity.v ----
// tsf_activity.v: synchronises one candidate clock pin and flags it dead when
// it shows no edge for a set time; assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
module tsf_activity #(
  parameter DEAD_CYCLES = 10000
) (
  // clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // candidate pin
  input  wire clk_pin,
  // synchronised level and health
  output reg  level,
  output reg  alive
);
  reg        sync1_reg;
  reg        sync2_reg;
  reg [15:0] idle_reg;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      level     <= 1'b0;
      idle_reg  <= 16'h0000;
      alive     <= 1'b0;
    end else begin
      sync1_reg <= clk_pin;
      sync2_reg <= sync1_reg;
      level     <= sync2_reg;
      // any edge restarts the idle count; silence past the limit is failure
      if (sync2_reg != level) begin
        idle_reg <= 16'h0000;
        alive    <= 1'b1;
      end else if (idle_reg >= DEAD_CYCLES[15:0]) begin
        alive <= 1'b0;
      end else begin
        idle_reg <= idle_reg + 16'h0001;
      end
    end
  end
endmodule

// ---- tsf_switch.v ----
// tsf_switch.v: runt-free selector of the distributed timing clock
// assumes all candidate levels are already in the ref_clk domain
`timescale 1ns/1ps
module tsf_switch (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // selection and candidates
  input  wire [3:0]  sel,
  input  wire [10:0] levels,
  input  wire [10:0] alive,
  // distributed clock
  output reg         clk_out,
  output reg  [3:0]  cur_sel
);
  reg parked_reg;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      clk_out    <= 1'b0;
      cur_sel    <= 4'h0;
      parked_reg <= 1'b1;
    end else if (parked_reg) begin
      // output held low until the new source is low, so its first high is whole
      clk_out <= 1'b0;
      // a dead source stuck high must not keep the switch parked
      if (sel != cur_sel && !alive[cur_sel])
        cur_sel <= sel;
      else if (!levels[cur_sel])
        parked_reg <= 1'b0;
    end else if (sel != cur_sel && (!levels[cur_sel] || !alive[cur_sel])) begin
      // leave the old source only in its low phase, or at once if it died
      clk_out    <= 1'b0;
      cur_sel    <= sel;
      parked_reg <= 1'b1;
    end else begin
      clk_out <= levels[cur_sel];
    end
  end
endmodule

// ---- tsf_failover.v ----
// tsf_failover.v: timing source selection with primary/secondary failover
// assumes candidate clocks arrive on pins asynchronous to ref_clk and that
// software reaches the configuration over Avalon-MM with waitrequest
//
// Contract
// - six primary choices: link one, link two, drop/insert, internal, external, sync data
// - selected active source times all logic and every external interface; here it only drives timing_clk_out, the block itself runs on ref_clk
// - primary failure switches automatically to the configured secondary source
// - same choice for both rejected, except internal and sync data
// - at most one application module clock source across both selections
// - revert to primary only after it stays stable for 10 seconds
// - secondary failure in use switches to internal; primary revert still applies
// - secondary selection defaults to internal clock
// - drop/insert choice allowed only while that port's interface is enabled
// - external choice uses a disabled sync data port's transmit clock
// - sync data choice uses an enabled sync data port's transmit clock
// - per-source slot/port selector, default first port, used for drop/insert, external/sync
// - external clock rate 8, 1544 or 2048 kHz, default 1544
// - external rate setting takes effect only when a source is external
// - primary failure raises alarm message only while its enable is set
// - secondary failure raises alarm message only while its enable is set
`timescale 1ns/1ps
`include "tsf_defs.vh"
module tsf_failover #(
  parameter STABLE_CYCLES = `TSF_STABLE_CYCLES,
  parameter DEAD_CYCLES   = `TSF_DEAD_CYCLES
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // avalon-mm slave
  input  wire [2:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // candidate clock pins
  input  wire        network_link_one,
  input  wire        network_link_two,
  input  wire [3:0]  drop_insert_port_source,
  input  wire [3:0]  ext_transmit_clock_in,
  // distributed timing
  output wire        timing_clk_out,
  output reg  [2:0]  active_source,
  output reg  [1:0]  ext_clk_rate,
  output reg         ext_clk_rate_valid,
  // alarm message requests and interrupt
  output reg         pri_fail_alarm,
  output reg         sec_fail_alarm,
  output wire        irq
);
  localparam ST_PRI = 2'h0;
  localparam ST_SEC = 2'h1;
  localparam ST_INT = 2'h2;

  // maps a source choice and port to the candidate level index
  function [3:0] cand_index;
    input [2:0] src;
    input [1:0] port;
    begin
      case (src)
        `TSF_SRC_NETWORK_LINK_ONE: cand_index = 4'h0;
        `TSF_SRC_NETWORK_LINK_TWO: cand_index = 4'h1;
        `TSF_SRC_DROP: cand_index = `TSF_CAND_DROP0 + {2'b00, port};
        `TSF_SRC_EXT:  cand_index = `TSF_CAND_XTC0 + {2'b00, port};
        `TSF_SRC_SYNC: cand_index = `TSF_CAND_XTC0 + {2'b00, port};
        default:       cand_index = `TSF_CAND_INT;
      endcase
    end
  endfunction

  // true when a choice may be offered given the port enables
  function src_offered;
    input [2:0] src;
    input [1:0] port;
    input [3:0] sync_en;
    input [3:0] drop_en;
    begin
      case (src)
        `TSF_SRC_NETWORK_LINK_ONE: src_offered = 1'b1;
        `TSF_SRC_NETWORK_LINK_TWO: src_offered = 1'b1;
        `TSF_SRC_INT:  src_offered = 1'b1;
        `TSF_SRC_DROP: src_offered = drop_en[port];
        `TSF_SRC_EXT:  src_offered = !sync_en[port];
        `TSF_SRC_SYNC: src_offered = sync_en[port];
        default:       src_offered = 1'b0;
      endcase
    end
  endfunction

  // application module sources: drop/insert, external and sync data ports
  function is_app;
    input [2:0] src;
    begin
      is_app = (src == `TSF_SRC_DROP) || (src == `TSF_SRC_EXT) ||
               (src == `TSF_SRC_SYNC);
    end
  endfunction

  // configuration and interrupt registers
  reg  [2:0]  pri_src_reg;
  reg  [2:0]  sec_src_reg;
  reg  [1:0]  rate_reg;
  reg         pri_alm_en_reg;
  reg         sec_alm_en_reg;
  reg  [1:0]  pri_port_reg;
  reg  [1:0]  sec_port_reg;
  reg  [3:0]  sync_en_reg;
  reg  [3:0]  drop_en_reg;
  reg  [3:0]  irq_stat_reg;
  reg  [3:0]  irq_mask_reg;
  reg         ack_reg;

  // failover state
  reg  [1:0]  state_reg;
  reg  [28:0] stable_reg;
  reg         pri_alive_d_reg;
  reg         sec_alive_d_reg;
  reg  [4:0]  int_div_reg;
  reg         int_level_reg;

  wire [10:0] levels;
  wire [10:0] alive;
  wire [9:0]  pins;
  wire [3:0]  sel_index;
  wire [3:0]  cur_index;

  assign pins = {ext_transmit_clock_in, drop_insert_port_source,
                 network_link_two, network_link_one};

  // one activity monitor per pin candidate
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_mon
      tsf_activity #(
        .DEAD_CYCLES (DEAD_CYCLES)
      ) u_mon (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clk_pin (pins[gi]),
        .level   (levels[gi]),
        .alive   (alive[gi])
      );
    end
  endgenerate

  // internal oscillator: divided reference, never fails
  always @(posedge ref_clk) begin
    if (!rstn) begin
      int_div_reg   <= 5'h00;
      int_level_reg <= 1'b0;
    end else if (int_div_reg == `TSF_INT_HALF_CYCLES - 1) begin
      int_div_reg   <= 5'h00;
      int_level_reg <= ~int_level_reg;
    end else begin
      int_div_reg <= int_div_reg + 5'h01;
    end
  end
  assign levels[10] = int_level_reg;
  assign alive[10]  = 1'b1;

  // ---------------------------------------------------------------- bus slave
  wire        req      = avs_read | avs_write;
  wire        wr_now   = avs_write & ack_reg;
  wire        rd_now   = avs_read & ack_reg;
  wire [2:0]  w_pri    = avs_writedata[`TSF_CTRL_PRI_LSB +: 3];
  wire [2:0]  w_sec    = avs_writedata[`TSF_CTRL_SEC_LSB +: 3];
  wire [1:0]  w_rate   = avs_writedata[`TSF_CTRL_RATE_LSB +: 2];
  wire [1:0]  w_pport  = avs_writedata[1:0];
  wire [1:0]  w_sport  = avs_writedata[3:2];
  wire [3:0]  w_sync   = avs_writedata[3:0];
  wire [3:0]  w_drop   = avs_writedata[7:4];

  // candidate configuration after this write, used for the legality check
  reg  [2:0]  c_pri;
  reg  [2:0]  c_sec;
  reg  [1:0]  c_rate;
  reg  [1:0]  c_pport;
  reg  [1:0]  c_sport;
  reg  [3:0]  c_sync;
  reg  [3:0]  c_drop;
  reg         c_ok;
  reg         cfg_wr;
  always @* begin
    c_pri   = pri_src_reg;
    c_sec   = sec_src_reg;
    c_rate  = rate_reg;
    c_pport = pri_port_reg;
    c_sport = sec_port_reg;
    c_sync  = sync_en_reg;
    c_drop  = drop_en_reg;
    cfg_wr  = 1'b0;
    if (wr_now) begin
      case (avs_address)
        `TSF_REG_CTRL: begin
          c_pri  = w_pri;
          c_sec  = w_sec;
          c_rate = w_rate;
          cfg_wr = 1'b1;
        end
        `TSF_REG_PORTSEL: begin
          c_pport = w_pport;
          c_sport = w_sport;
          cfg_wr  = 1'b1;
        end
        `TSF_REG_PORTCFG: begin
          c_sync = w_sync;
          c_drop = w_drop;
          cfg_wr = 1'b1;
        end
        default: cfg_wr = 1'b0;
      endcase
    end
    c_ok = src_offered(c_pri, c_pport, c_sync, c_drop) &&
           src_offered(c_sec, c_sport, c_sync, c_drop) &&
           (c_rate != 2'h3);
    if (c_pri == c_sec && c_pri != `TSF_SRC_INT && c_pri != `TSF_SRC_SYNC)
      c_ok = 1'b0;
    if (is_app(c_pri) && is_app(c_sec) &&
        !(c_pri == `TSF_SRC_SYNC && c_sec == `TSF_SRC_SYNC && c_pport == c_sport))
      c_ok = 1'b0;
  end

  wire [31:0] status_word = {14'h0000, alive, 1'b0, state_reg, 1'b0, active_source};
  wire [31:0] ctrl_word   = {18'h00000, sec_alm_en_reg, pri_alm_en_reg, 2'b00,
                             rate_reg, 1'b0, sec_src_reg, 1'b0, pri_src_reg};

  reg  [31:0] rd_mux;
  always @* begin
    case (avs_address)
      `TSF_REG_CTRL:     rd_mux = ctrl_word;
      `TSF_REG_PORTSEL:  rd_mux = {28'h0000000, sec_port_reg, pri_port_reg};
      `TSF_REG_PORTCFG:  rd_mux = {24'h000000, drop_en_reg, sync_en_reg};
      `TSF_REG_STATUS:   rd_mux = status_word;
      `TSF_REG_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_reg};
      `TSF_REG_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_reg};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // every request answers one cycle after it is raised
  assign avs_waitrequest = req & ~ack_reg;

  // ------------------------------------------------------------ failover FSM
  wire [3:0] pri_idx   = cand_index(pri_src_reg, pri_port_reg);
  wire [3:0] sec_idx   = cand_index(sec_src_reg, sec_port_reg);
  wire       pri_alive = alive[pri_idx];
  wire       sec_alive = alive[sec_idx];
  wire       pri_fail  = pri_alive_d_reg & ~pri_alive;
  wire       sec_fail  = sec_alive_d_reg & ~sec_alive & (state_reg == ST_SEC);
  reg  [1:0] state_next;
  reg        revert;
  always @* begin
    state_next = state_reg;
    revert     = 1'b0;
    case (state_reg)
      ST_PRI: begin
        if (!pri_alive)
          state_next = sec_alive ? ST_SEC : ST_INT;
      end
      ST_SEC: begin
        if (pri_alive && stable_reg >= STABLE_CYCLES - 1) begin
          state_next = ST_PRI;
          revert     = 1'b1;
        end else if (!sec_alive) begin
          state_next = ST_INT;
        end
      end
      ST_INT: begin
        if (pri_alive && stable_reg >= STABLE_CYCLES - 1) begin
          state_next = ST_PRI;
          revert     = 1'b1;
        end
      end
      default: state_next = ST_PRI;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      pri_src_reg     <= `TSF_SRC_NETWORK_LINK_ONE;
      sec_src_reg     <= `TSF_SRC_INT;
      rate_reg        <= `TSF_RATE_1544K;
      pri_alm_en_reg  <= 1'b1;
      sec_alm_en_reg  <= 1'b1;
      pri_port_reg    <= 2'h0;
      sec_port_reg    <= 2'h0;
      sync_en_reg     <= 4'h0;
      drop_en_reg     <= 4'h0;
      irq_stat_reg    <= 4'h0;
      irq_mask_reg    <= 4'h0;
      ack_reg         <= 1'b0;
      avs_readdata    <= 32'h0000_0000;
      state_reg       <= ST_PRI;
      stable_reg      <= 29'h0000_0000;
      pri_alive_d_reg <= 1'b0;
      sec_alive_d_reg <= 1'b0;
      pri_fail_alarm  <= 1'b0;
      sec_fail_alarm  <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg)
        avs_readdata <= rd_mux;
      // legal configuration is applied whole; an illegal one is dropped, but a CTRL write still sets the alarm enables
      if (cfg_wr && c_ok) begin
        pri_src_reg  <= c_pri;
        sec_src_reg  <= c_sec;
        rate_reg     <= c_rate;
        pri_port_reg <= c_pport;
        sec_port_reg <= c_sport;
        sync_en_reg  <= c_sync;
        drop_en_reg  <= c_drop;
      end
      if (wr_now && avs_address == `TSF_REG_CTRL) begin
        pri_alm_en_reg <= avs_writedata[`TSF_CTRL_PRI_ALM];
        sec_alm_en_reg <= avs_writedata[`TSF_CTRL_SEC_ALM];
      end
      if (wr_now && avs_address == `TSF_REG_IRQ_MASK)
        irq_mask_reg <= avs_writedata[3:0];
      // read clears only the bits it reported; a same-cycle event still sets
      irq_stat_reg <= ((rd_now && avs_address == `TSF_REG_IRQ_STAT) ?
                       (irq_stat_reg & ~avs_readdata[3:0]) : irq_stat_reg)
                      | {cfg_wr & ~c_ok, revert, sec_fail, pri_fail};
      state_reg       <= state_next;
      pri_alive_d_reg <= pri_alive;
      sec_alive_d_reg <= sec_alive;
      // stability timer runs only while primary is back, restarts on relapse
      if (!pri_alive || state_reg == ST_PRI || revert)
        stable_reg <= 29'h0000_0000;
      else if (stable_reg < STABLE_CYCLES - 1)
        stable_reg <= stable_reg + 29'h0000_0001;
      pri_fail_alarm <= pri_fail & pri_alm_en_reg;
      sec_fail_alarm <= sec_fail & sec_alm_en_reg;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // active source and the external rate that goes with it
  always @(posedge ref_clk) begin
    if (!rstn) begin
      active_source      <= `TSF_SRC_NETWORK_LINK_ONE;
      ext_clk_rate       <= `TSF_RATE_1544K;
      ext_clk_rate_valid <= 1'b0;
    end else begin
      case (state_next)
        ST_PRI:  active_source <= pri_src_reg;
        ST_SEC:  active_source <= sec_src_reg;
        default: active_source <= `TSF_SRC_INT;
      endcase
      ext_clk_rate_valid <= (pri_src_reg == `TSF_SRC_EXT) ||
                            (sec_src_reg == `TSF_SRC_EXT);
      if ((pri_src_reg == `TSF_SRC_EXT) || (sec_src_reg == `TSF_SRC_EXT))
        ext_clk_rate <= rate_reg;
    end
  end

  assign sel_index = (state_reg == ST_PRI) ? pri_idx :
                     (state_reg == ST_SEC) ? sec_idx : `TSF_CAND_INT;

  tsf_switch u_switch (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sel     (sel_index),
    .levels  (levels),
    .alive   (alive),
    .clk_out (timing_clk_out),
    .cur_sel (cur_index)
  );

  // the data link rate offset is the attached equipment's duty; no check here
  wire unused_cur = |cur_index;
endmodule

// ---- tsf_failover_properties.sv ----
// tsf_failover_properties.sv: port-level checks of the timing source failover block
// assumes a master that holds each Avalon request until waitrequest is low
`timescale 1ns/1ps
module tsf_failover_props #(
  parameter STABLE_CYCLES = 200,
  parameter DEAD_CYCLES   = 40
) (
  // clock and reset
  input wire        ref_clk,
  input wire        rstn,
  // avalon-mm slave
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // distributed timing and alarms
  input wire        timing_clk_out,
  input wire [2:0]  active_source,
  input wire [1:0]  ext_clk_rate,
  input wire        ext_clk_rate_valid,
  input wire        pri_fail_alarm,
  input wire        sec_fail_alarm
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait");
  property p_wait_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest high with no request");
  property p_rd_stand;
    $changed(avs_readdata) |-> avs_read && !avs_waitrequest;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("readdata moved outside a read answer");
  property p_src_legal;
    active_source <= 3'h5;
  endproperty
  a_src_legal: assert property (p_src_legal) else $error("unknown active source code");
  property p_rate_legal;
    ext_clk_rate != 2'h3;
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("external rate code out of range");
  property p_rate_hold;
    !ext_clk_rate_valid && !$past(ext_clk_rate_valid) |-> $stable(ext_clk_rate);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed with no external source");
  property p_pri_pulse;
    pri_fail_alarm |=> !pri_fail_alarm;
  endproperty
  a_pri_pulse: assert property (p_pri_pulse) else $error("primary alarm longer than one cycle");
  property p_sec_pulse;
    sec_fail_alarm |=> !sec_fail_alarm;
  endproperty
  a_sec_pulse: assert property (p_sec_pulse) else $error("secondary alarm longer than one cycle");
  property p_no_runt;
    $rose(timing_clk_out) |=> timing_clk_out;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("runt high pulse on timing clock");
endmodule

bind tsf_failover tsf_failover_props #(
  .STABLE_CYCLES(STABLE_CYCLES),
  .DEAD_CYCLES  (DEAD_CYCLES)
) i_tsf_failover_props (
  .ref_clk           (ref_clk),
  .rstn              (rstn),
  .avs_read          (avs_read),
  .avs_write         (avs_write),
  .avs_readdata      (avs_readdata),
  .avs_waitrequest   (avs_waitrequest),
  .timing_clk_out    (timing_clk_out),
  .active_source     (active_source),
  .ext_clk_rate      (ext_clk_rate),
  .ext_clk_rate_valid(ext_clk_rate_valid),
  .pri_fail_alarm    (pri_fail_alarm),
  .sec_fail_alarm    (sec_fail_alarm)
);

// ---- tsf_clk_src.sv ----
// tsf_clk_src.sv: far-side candidate clocks, links, drop/insert and sync data ports
// assumes nothing of ref_clk; each clock free-runs at its own unrelated period
`timescale 1ns/1ps
module tsf_clk_src (
  // per-pin run enables
  input  wire [9:0] run,
  // candidate pins: 0 link one, 1 link two, 5:2 drop/insert, 9:6 sync transmit
  output wire [9:0] pins
);
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gen_src
      reg q = 1'b0;
      // a stopped source stands low; sync ports run slowest, as with a data link on
      always begin
        #(60 + 11 * g);
        q = run[g] ? ~q : 1'b0;
      end
      assign pins[g] = q;
    end
  endgenerate
endmodule

// ---- timing_source_failover_test.sv ----
// timing_source_failover_test.sv: self-checking bench of the failover block
// assumes tsf_defs.vh and the candidate clock model tsf_clk_src
`timescale 1ns/1ps
`include "tsf_defs.vh"
module timing_source_failover_test;
  localparam STAB = 200;
  reg         ref_clk       = 1'b0;
  reg         rstn          = 1'b0;
  reg  [2:0]  avs_address   = 3'h0;
  reg         avs_read      = 1'b0;
  reg         avs_write     = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [9:0]  run           = 10'h3ff;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [9:0]  pins;
  wire        timing_clk_out;
  wire [2:0]  active_source;
  wire [1:0]  ext_clk_rate;
  wire        ext_clk_rate_valid;
  wire        pri_fail_alarm;
  wire        sec_fail_alarm;
  wire        irq;
  int         fail_count    = 0;
  int         cmp_count     = 0;
  int         cyc           = 0;
  reg  [31:0] m_ctrl        = 32'h3130;
  reg  [31:0] m_psel        = 32'h0;
  reg  [31:0] m_pcfg        = 32'h0;
  reg  [1:0]  m_rate        = 2'h1;
  reg  [35:0] tab [0:13];

  tsf_clk_src i_tsf_clk_src (.run(run), .pins(pins));
  tsf_failover #(.STABLE_CYCLES(STAB), .DEAD_CYCLES(40)) i_tsf_failover (
    .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .network_link_one(pins[0]),
    .network_link_two(pins[1]), .drop_insert_port_source(pins[5:2]),
    .ext_transmit_clock_in(pins[9:6]), .timing_clk_out(timing_clk_out),
    .active_source(active_source), .ext_clk_rate(ext_clk_rate),
    .ext_clk_rate_valid(ext_clk_rate_valid), .pri_fail_alarm(pri_fail_alarm),
    .sec_fail_alarm(sec_fail_alarm), .irq(irq));

  always #12.5 ref_clk = ~ref_clk;

  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task bus(input w, input [2:0] a, input [31:0] v, output [31:0] d);
    int n;
    begin
      @(posedge ref_clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= v;
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      check(n < 100, 1);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  function automatic bit src_ok(input [2:0] s, input [1:0] pt, input [7:0] g);
    begin
      case (s)
        `TSF_SRC_DROP: src_ok = g[4 + pt];
        `TSF_SRC_EXT: src_ok = !g[pt];
        `TSF_SRC_SYNC: src_ok = g[pt];
        default: src_ok = 1'b1;
      endcase
    end
  endfunction

  function automatic bit cfg_ok(input [31:0] c, input [31:0] ps, input [31:0] g);
    reg [2:0] p;
    reg [2:0] s;
    reg       ap;
    reg       as;
    begin
      p = c[2:0];
      s = c[6:4];
      ap = (p == `TSF_SRC_DROP || p == `TSF_SRC_EXT || p == `TSF_SRC_SYNC);
      as = (s == `TSF_SRC_DROP || s == `TSF_SRC_EXT || s == `TSF_SRC_SYNC);
      cfg_ok = c[9:8] != 2'h3 && (p != s || p == `TSF_SRC_INT || p == `TSF_SRC_SYNC)
        && !(ap && as && !(p == `TSF_SRC_SYNC && s == p && ps[1:0] == ps[3:2]))
        && src_ok(p, ps[1:0], g[7:0]) && src_ok(s, ps[3:2], g[7:0]);
    end
  endfunction

  task cfg_wr(input [2:0] a, input [31:0] v);
    reg [31:0] c;
    reg [31:0] ps;
    reg [31:0] g;
    reg [31:0] d;
    reg        ok;
    begin
      c = (a == `TSF_REG_CTRL) ? v : m_ctrl;
      ps = (a == `TSF_REG_PORTSEL) ? v : m_psel;
      g = (a == `TSF_REG_PORTCFG) ? v : m_pcfg;
      ok = cfg_ok(c, ps, g);
      if (ok) begin
        m_ctrl = c & 32'h3377;
        m_psel = ps & 32'hf;
        m_pcfg = g & 32'hff;
      end else if (a == `TSF_REG_CTRL)
        m_ctrl[13:12] = v[13:12];
      if (m_ctrl[2:0] == `TSF_SRC_EXT || m_ctrl[6:4] == `TSF_SRC_EXT)
        m_rate = m_ctrl[9:8];
      bus(1'b1, a, v, d);
      bus(1'b0, `TSF_REG_IRQ_STAT, 32'h0, d);
      check(d[`TSF_IRQ_CFG_REJ], !ok);
      bus(1'b0, a, 32'h0, d);
      check(d, a == 3'h0 ? m_ctrl : a == 3'h1 ? m_psel : m_pcfg);
      check(ext_clk_rate_valid, m_ctrl[2:0] == 4 || m_ctrl[6:4] == 4);
      check(ext_clk_rate, m_rate);
    end
  endtask

  task watch(input int c, output reg pa, output reg sa);
    begin
      pa = 1'b0;
      sa = 1'b0;
      repeat (c) begin
        @(negedge ref_clk);
        pa = pa | (pri_fail_alarm === 1'b1);
        sa = sa | (sec_fail_alarm === 1'b1);
      end
    end
  endtask

  task wait_src(input [2:0] s, output int n);
    begin
      n = 0;
      while (active_source !== s && n < 1000) begin
        @(negedge ref_clk);
        n = n + 1;
      end
    end
  endtask

  initial begin : main
    reg [31:0] d;
    reg        pa;
    reg        sa;
    int        n;
    int        i;
    i = $urandom(32'h9cb73cef);
    tab = '{36'h000003100, 36'h200000011, 36'h000003111, 36'h000003133, 36'h000003155,
            36'h000003124, 36'h000003102, 36'h000003140, 36'h000003104, 36'h200000010,
            36'h000003104, 36'h000003204, 36'h000003334, 36'h000003155};
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b1, 3'h6, 32'hffffffff, d);
    bus(1'b0, `TSF_REG_CTRL, 32'h0, d);
    check(d, `TSF_CTRL_RESET);
    for (i = 1; i < 7; i = i + 1) begin
      if (i == 3 || i == 4)
        continue;
      bus(1'b0, i[2:0], 32'h0, d);
      check(d, 32'h0);
    end
    wait_src(`TSF_SRC_NETWORK_LINK_ONE, n);
    check(active_source, `TSF_SRC_NETWORK_LINK_ONE);
    for (i = 0; i < 14; i = i + 1)
      cfg_wr(tab[i][34:32], tab[i][31:0]);
    for (i = 0; i < 40; i = i + 1)
      case ($urandom % 3)
        0: cfg_wr(3'h0, ($urandom & 32'h3300) | ($urandom % 6) | (($urandom % 6) << 4));
        1: cfg_wr(3'h1, $urandom & 32'hf);
        default: cfg_wr(3'h2, $urandom & 32'hff);
      endcase
    cfg_wr(3'h0, 32'h3110);
    bus(1'b1, `TSF_REG_IRQ_MASK, 32'hf, d);
    wait_src(`TSF_SRC_NETWORK_LINK_ONE, n);
    bus(1'b0, `TSF_REG_IRQ_STAT, 32'h0, d);
    @(negedge ref_clk);
    check(irq, 1'b0);
    run[0] <= 1'b0;
    watch(120, pa, sa);
    check(pa, 1'b1);
    check(sa, 1'b0);
    check(active_source, `TSF_SRC_NETWORK_LINK_TWO);
    check(irq, 1'b1);
    bus(1'b0, `TSF_REG_IRQ_STAT, 32'h0, d);
    check(d[`TSF_IRQ_PRI_FAIL], 1'b1);
    run[1] <= 1'b0;
    watch(120, pa, sa);
    check(sa, 1'b1);
    check(active_source, `TSF_SRC_INT);
    run[0] <= 1'b1;
    repeat (150) @(posedge ref_clk);
    run[0] <= 1'b0;
    repeat (80) @(posedge ref_clk);
    check(active_source, `TSF_SRC_INT);
    run[0] <= 1'b1;
    wait_src(`TSF_SRC_NETWORK_LINK_ONE, n);
    check(n >= STAB && n <= STAB + 60, 1'b1);
    bus(1'b0, `TSF_REG_IRQ_STAT, 32'h0, d);
    check(d[`TSF_IRQ_REVERT], 1'b1);
    run[1] <= 1'b1;
    cfg_wr(3'h0, 32'h2110);
    run[0] <= 1'b0;
    watch(120, pa, sa);
    check(pa, 1'b0);
    check(active_source, `TSF_SRC_NETWORK_LINK_TWO);
    // link two runs at a 142 ns period: 17 or 18 rises in 100 reference cycles
    n = 0;
    pa = 1'b0;
    repeat (100) begin
      @(negedge ref_clk);
      n = n + (timing_clk_out === 1'b1 && !pa);
      pa = (timing_clk_out === 1'b1);
    end
    check(n >= 16 && n <= 19, 1'b1);
    stop_test;
  end
endmodule
